// ---- hdl/dqsie_pkg.sv ----
// Purpose: Constants and carrier types of the queued-status and completion
//          interrupt-enable register bank of a 64-channel DMA controller.
// Assumes: One clock, synchronous active-low reset, classic Wishbone slave.
// Notes:   All register offsets are byte addresses of aligned 32-bit words.
//
// Function
// - A channel's queued-status bit is set when a manual, external or chained trigger is taken.
// - While a channel's queued-status bit is set, no further event of that channel is submitted.
// - Events of a channel are evaluated again only after its queued-status bit is cleared.
// - Queued-status reads return 1 for a queued event and 0 otherwise, reset to zero, read-only.
// - Writing 1 to a queued-status clear bit clears that status bit; 0 leaves it alone.
// - A channel may raise the completion interrupt only while its enable bit is 1.
// - Direct writes to the enable banks do nothing; only set and clear writes change them.
// - Writing 1 to an enable clear bit clears that enable bit; 0 leaves it alone.
// - Low registers hold channels 0 to 31 and high registers channels 32 to 63, bit per channel.
// - Any channel whose enable bit is 1 may raise the completion interrupt when its transfer completes.
// - Writing 1 to an enable set bit sets that enable bit; 0 leaves it alone.
// - A completion code n sets pending bit n, codes 0 to 31 low and 32 to 63 high.
package dqsie_pkg;

    localparam int NCH = 64;
    localparam int HALF = 32;
    localparam int ADR_W = 8;

    // Register byte offsets.
    localparam logic [ADR_W-1:0] OFS_QS_LO = 8'h00;
    localparam logic [ADR_W-1:0] OFS_QS_HI = 8'h04;
    localparam logic [ADR_W-1:0] OFS_QS_CLR_LO = 8'h08;
    localparam logic [ADR_W-1:0] OFS_QS_CLR_HI = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_EN_LO = 8'h10;
    localparam logic [ADR_W-1:0] OFS_EN_HI = 8'h14;
    localparam logic [ADR_W-1:0] OFS_DIS_LO = 8'h18;
    localparam logic [ADR_W-1:0] OFS_DIS_HI = 8'h1C;
    localparam logic [ADR_W-1:0] OFS_ENSET_LO = 8'h20;
    localparam logic [ADR_W-1:0] OFS_ENSET_HI = 8'h24;
    localparam logic [ADR_W-1:0] OFS_PEND_LO = 8'h28;
    localparam logic [ADR_W-1:0] OFS_PEND_HI = 8'h2C;
    localparam logic [ADR_W-1:0] OFS_PEND_CLR_LO = 8'h30;
    localparam logic [ADR_W-1:0] OFS_PEND_CLR_HI = 8'h34;

    // Reset values and fillers.
    localparam logic [NCH-1:0] BANK_RST = 64'h0000_0000_0000_0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] WORD_ONES = 32'hFFFF_FFFF;

    // Entry taken from the event queue by the transfer side.
    typedef struct packed {
        logic valid;
        logic [5:0] chan;
        logic hw_clear;
    } dqsie_deq_s;

    // Completion code returned on transfer completion.
    typedef struct packed {
        logic valid;
        logic [5:0] code;
    } dqsie_cmp_s;

endpackage : dqsie_pkg

// ---- hdl/dqsie_bank.sv ----
// Purpose: Bank of 64 sticky bits with per-bit set and clear vectors.
// Assumes: Set and clear vectors come from logic on the same clock.
// Notes:   A set beats a clear of the same bit in the same cycle.
`timescale 1ns/1ps

module dqsie_bank
    import dqsie_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // Per-bit requests.
    input wire logic [NCH-1:0] set_vec,
    input wire logic [NCH-1:0] clr_vec,
    // Stored bits.
    output logic [NCH-1:0] bits
);

    ////////////////////////////////////////////////////////////////////////////////
    // One flip-flop per bit; giving the set priority means no event is lost to a
    // clear racing with it.
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++)
        begin : g_bit
            always_ff @(posedge clock)
            begin
                if (!rst_b)
                    bits[gi] <= BANK_RST[gi];
                else if (ce)
                    bits[gi] <= set_vec[gi] | (bits[gi] & ~clr_vec[gi]);
            end
        end
    endgenerate

endmodule : dqsie_bank

// ---- hdl/dqsie_top.sv ----
// Purpose: Queued-status bank, completion-enable bank and completion pending
//          bits of a 64-channel DMA controller, reached over classic Wishbone.
// Assumes: Trigger, dequeue and completion inputs come from logic on clock.
// Notes:   Every access is answered one cycle after it is seen.
`timescale 1ns/1ps

module dqsie_top
    import dqsie_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // Wishbone slave.
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // Trigger sources, one bit per channel.
    input wire logic [NCH-1:0] manual_trigger_set,
    input wire logic [NCH-1:0] external_event_latch,
    input wire logic [NCH-1:0] chained_event_latch,
    // Queue and completion side.
    input wire dqsie_deq_s deq,
    input wire dqsie_cmp_s cmp,
    output logic [NCH-1:0] transfer_request,
    // Completion interrupt.
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode.
    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic [NCH-1:0] qs_bits;
    logic [NCH-1:0] en_bits;
    logic [NCH-1:0] pend_bits;

    wire req = wb_cyc && wb_stb && !ack_r;
    wire wr_go = ce && req && wb_we;
    wire rd_go = ce && req && !wb_we;
    wire [31:0] wmask = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
    wire [31:0] wbits = wb_dat_w & wmask;

    // Write strobes; direct writes to the enable words have no decode at all.
    wire wr_qs_clr_lo = wr_go && (wb_adr == OFS_QS_CLR_LO);
    wire wr_qs_clr_hi = wr_go && (wb_adr == OFS_QS_CLR_HI);
    wire wr_dis_lo = wr_go && (wb_adr == OFS_DIS_LO);
    wire wr_dis_hi = wr_go && (wb_adr == OFS_DIS_HI);
    wire wr_enset_lo = wr_go && (wb_adr == OFS_ENSET_LO);
    wire wr_enset_hi = wr_go && (wb_adr == OFS_ENSET_HI);
    wire wr_pclr_lo = wr_go && (wb_adr == OFS_PEND_CLR_LO);
    wire wr_pclr_hi = wr_go && (wb_adr == OFS_PEND_CLR_HI);

    // Low word serves channels 0 to 31, high word channels 32 to 63.
    wire [NCH-1:0] qs_sw_clr = {wr_qs_clr_hi ? wbits : WORD_ZERO,
                                wr_qs_clr_lo ? wbits : WORD_ZERO};
    wire [NCH-1:0] en_clr = {wr_dis_hi ? wbits : WORD_ZERO,
                             wr_dis_lo ? wbits : WORD_ZERO};
    wire [NCH-1:0] en_set = {wr_enset_hi ? wbits : WORD_ZERO,
                             wr_enset_lo ? wbits : WORD_ZERO};
    wire [NCH-1:0] pend_clr = {wr_pclr_hi ? wbits : WORD_ZERO,
                               wr_pclr_lo ? wbits : WORD_ZERO};

    // Read mux; write-only and unmapped words read as zero.
    always_comb
    begin
        if (wb_adr == OFS_QS_LO)
            dat_nxt = qs_bits[HALF-1:0];
        else if (wb_adr == OFS_QS_HI)
            dat_nxt = qs_bits[NCH-1:HALF];
        else if (wb_adr == OFS_EN_LO)
            dat_nxt = en_bits[HALF-1:0];
        else if (wb_adr == OFS_EN_HI)
            dat_nxt = en_bits[NCH-1:HALF];
        else if (wb_adr == OFS_PEND_LO)
            dat_nxt = pend_bits[HALF-1:0];
        else if (wb_adr == OFS_PEND_HI)
            dat_nxt = pend_bits[NCH-1:HALF];
        else
            dat_nxt = WORD_ZERO;
    end

    // Ack rises one cycle after the request and falls the cycle after.
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            ack_r <= 1'b0;
        else if (ce)
            ack_r <= wb_cyc && wb_stb && !ack_r;
    end

    // Read data is captured with the ack and zero otherwise.
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            dat_r <= WORD_ZERO;
        else if (ce)
            dat_r <= rd_go ? dat_nxt : WORD_ZERO;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event acceptance and queued status.
    logic [NCH-1:0] treq_r;
    wire [NCH-1:0] trig = manual_trigger_set | external_event_latch | chained_event_latch;
    // A channel already queued ignores new triggers until its status clears.
    wire [NCH-1:0] accept = trig & ~qs_bits;
    wire [NCH-1:0] deq_dec = NCH'(1) << deq.chan;
    wire [NCH-1:0] qs_hw_clr = (deq.valid && deq.hw_clear) ? deq_dec : BANK_RST;

    // Queued-status bank: set by accepted triggers, cleared by hardware or software.
    dqsie_bank u_qs
    (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .set_vec(accept),
        .clr_vec(qs_hw_clr | qs_sw_clr),
        .bits(qs_bits)
    );

    // Accepted events go to the queue as a one-cycle request vector.
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            treq_r <= BANK_RST;
        else if (ce)
            treq_r <= accept;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Completion enables, pending bits and the interrupt line.
    logic irq_r;
    wire [NCH-1:0] cmp_dec = NCH'(1) << cmp.code;
    wire [NCH-1:0] pend_set = cmp.valid ? cmp_dec : BANK_RST;

    // Enable bank is only reachable through the set and clear words.
    dqsie_bank u_en
    (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .set_vec(en_set),
        .clr_vec(en_clr),
        .bits(en_bits)
    );

    // Pending bank is sticky until software writes one to its clear word.
    dqsie_bank u_pend
    (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .set_vec(pend_set),
        .clr_vec(pend_clr),
        .bits(pend_bits)
    );

    // Level interrupt while any enabled channel has a pending completion.
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            irq_r <= 1'b0;
        else if (ce)
            irq_r <= |(pend_bits & en_bits);
    end

    assign wb_ack = ack_r;
    assign wb_dat_r = dat_r;
    assign transfer_request = treq_r;
    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_set;
        @(posedge clock) disable iff (!rst_b)
        (ce && (accept != BANK_RST)) |=> ((qs_bits & $past(accept)) == $past(accept));
    endproperty
    a_set: assert property (p_set) else $error("accepted trigger did not set status");

    property p_block;
        @(posedge clock) disable iff (!rst_b)
        ce |=> ((transfer_request & $past(qs_bits)) == BANK_RST);
    endproperty
    a_block: assert property (p_block) else $error("queued channel submitted again");

    property p_resume;
        @(posedge clock) disable iff (!rst_b)
        (ce && (qs_bits == BANK_RST) && (trig != BANK_RST))
            |=> (transfer_request == $past(trig));
    endproperty
    a_resume: assert property (p_resume) else $error("free channel not submitted");

    property p_read;
        @(posedge clock) disable iff (!rst_b)
        (rd_go && (wb_adr == OFS_QS_HI)) |=> (wb_ack && (wb_dat_r == $past(qs_bits[NCH-1:HALF])));
    endproperty
    a_read: assert property (p_read) else $error("status high read mismatch");

    property p_sw_clr;
        @(posedge clock) disable iff (!rst_b)
        (wr_qs_clr_lo && (wb_sel == 4'hF) && (accept[HALF-1:0] == WORD_ZERO))
            |=> ((qs_bits[HALF-1:0] & $past(wb_dat_w)) == WORD_ZERO);
    endproperty
    a_sw_clr: assert property (p_sw_clr) else $error("status clear write ignored");

    property p_direct;
        @(posedge clock) disable iff (!rst_b)
        (wr_go && ((wb_adr == OFS_EN_LO) || (wb_adr == OFS_EN_HI))) |=> $stable(en_bits);
    endproperty
    a_direct: assert property (p_direct) else $error("direct enable write took effect");

    property p_en_clr;
        @(posedge clock) disable iff (!rst_b)
        (wr_dis_hi && (wb_sel == 4'hF))
            |=> ((en_bits[NCH-1:HALF] & $past(wb_dat_w)) == WORD_ZERO);
    endproperty
    a_en_clr: assert property (p_en_clr) else $error("enable clear ignored");

    property p_en_set;
        @(posedge clock) disable iff (!rst_b)
        (wr_enset_lo && (wb_sel == 4'hF))
            |=> ((en_bits[HALF-1:0] & $past(wb_dat_w)) == $past(wb_dat_w))
                && (en_bits[NCH-1:HALF] == $past(en_bits[NCH-1:HALF]));
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable set wrong");

    property p_irq;
        @(posedge clock) disable iff (!rst_b)
        ce |=> (irq == $past(|(pend_bits & en_bits)));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    property p_pend;
        @(posedge clock) disable iff (!rst_b)
        (ce && cmp.valid) |=> pend_bits[$past(cmp.code)];
    endproperty
    a_pend: assert property (p_pend) else $error("completion code not recorded");

    property p_prio;
        @(posedge clock) disable iff (!rst_b)
        (ce && deq.valid && deq.hw_clear && accept[deq.chan]) |=> qs_bits[$past(deq.chan)];
    endproperty
    a_prio: assert property (p_prio) else $error("clear beat a set");

    property p_hw_clr;
        @(posedge clock) disable iff (!rst_b)
        (ce && deq.valid && deq.hw_clear && !accept[deq.chan]) |=> !qs_bits[$past(deq.chan)];
    endproperty
    a_hw_clr: assert property (p_hw_clr) else $error("dequeue did not clear status");

    // Low words, the high halves and untouched positions, which the checks above miss.
    property p_rd_lo;
        @(posedge clock) disable iff (!rst_b)
        (rd_go && (wb_adr == OFS_QS_LO))
            |=> (wb_ack && (wb_dat_r == $past(qs_bits[HALF-1:0])));
    endproperty
    a_rd_lo: assert property (p_rd_lo) else $error("status low read mismatch");

    property p_wo_rd;
        @(posedge clock) disable iff (!rst_b)
        (rd_go && (wb_adr == OFS_QS_CLR_LO)) |=> (wb_dat_r == WORD_ZERO);
    endproperty
    a_wo_rd: assert property (p_wo_rd) else $error("write-only word read non-zero");

    property p_sw_clr_hi;
        @(posedge clock) disable iff (!rst_b)
        (wr_qs_clr_hi && (wb_sel == 4'hF) && (accept[NCH-1:HALF] == WORD_ZERO))
            |=> ((qs_bits[NCH-1:HALF] & $past(wb_dat_w)) == WORD_ZERO);
    endproperty
    a_sw_clr_hi: assert property (p_sw_clr_hi) else $error("status high clear ignored");

    // A set status bit survives a clear write that has a zero in its position.
    property p_sw_keep;
        @(posedge clock) disable iff (!rst_b)
        (wr_qs_clr_lo && (wb_sel == 4'hF) && !(deq.valid && deq.hw_clear))
            |=> (((qs_bits[HALF-1:0] | $past(wb_dat_w)) & $past(qs_bits[HALF-1:0]))
                == $past(qs_bits[HALF-1:0]));
    endproperty
    a_sw_keep: assert property (p_sw_keep) else $error("status clear hit a zero bit");

    property p_en_clr_lo;
        @(posedge clock) disable iff (!rst_b)
        (wr_dis_lo && (wb_sel == 4'hF))
            |=> ((en_bits[HALF-1:0] & $past(wb_dat_w)) == WORD_ZERO);
    endproperty
    a_en_clr_lo: assert property (p_en_clr_lo) else $error("enable low clear ignored");

    property p_en_keep;
        @(posedge clock) disable iff (!rst_b)
        (wr_dis_lo && (wb_sel == 4'hF))
            |=> ((en_bits[HALF-1:0] | $past(wb_dat_w))
                == ($past(en_bits[HALF-1:0]) | $past(wb_dat_w)));
    endproperty
    a_en_keep: assert property (p_en_keep) else $error("enable clear hit a zero bit");

    property p_en_set_hi;
        @(posedge clock) disable iff (!rst_b)
        (wr_enset_hi && (wb_sel == 4'hF))
            |=> ((en_bits[NCH-1:HALF] & $past(wb_dat_w)) == $past(wb_dat_w));
    endproperty
    a_en_set_hi: assert property (p_en_set_hi) else $error("enable high set ignored");

    // A submitted channel is queued, so it cannot be submitted in the next cycle.
    property p_treq_pulse;
        @(posedge clock) disable iff (!rst_b)
        (ce && (transfer_request != BANK_RST))
            |=> ((transfer_request & $past(transfer_request)) == BANK_RST);
    endproperty
    a_treq_pulse: assert property (p_treq_pulse) else $error("request repeated");

    property p_irq_mask;
        @(posedge clock) disable iff (!rst_b)
        (ce && ((pend_bits & en_bits) == BANK_RST)) |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked completion raised irq");

endmodule : dqsie_top

// ---- sim/dqsie_top_tb.sv ----
// Purpose: Self-checking bench of the queued-status and completion-enable register bank.
// Assumes: Wishbone answer comes one cycle after a request is taken; the bench waits anyway.
// Notes:   Every scenario is its own task; each drives the ports and judges the result itself.
`timescale 1ns/1ps

module dqsie_top_tb
    import dqsie_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////////////
    // Stimulus signals, all given a value at time zero.
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [ADR_W-1:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_dat_w = 32'h0000_0000;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic [NCH-1:0] manual_trigger_set = '0;
    logic [NCH-1:0] external_event_latch = '0;
    logic [NCH-1:0] chained_event_latch = '0;
    dqsie_deq_s deq = '0;
    dqsie_cmp_s cmp = '0;
    logic [NCH-1:0] transfer_request;
    logic irq;
    int bad_count = 0;
    int check_count = 0;
    logic [63:0] v;

    // The clock toggles every half period of the 200 MHz rate.
    always #2.5 clock = ~clock;

    dqsie_top i_dqsie_top (.clock, .rst_b, .ce, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
        .wb_dat_w, .wb_dat_r, .wb_ack, .manual_trigger_set, .external_event_latch,
        .chained_event_latch, .deq, .cmp, .transfer_request, .irq);

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks.
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
            bad_count++;
        end
    endtask : chk

    // One classic cycle; the request is held until ack is seen, so no latency is assumed.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        output logic [31:0] rd);
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= dat;
        do
        begin
            @(posedge clock);
        end
        while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        // Ack is a single-cycle pulse, so it must be gone at the next edge.
        @(posedge clock);
        chk(wb_ack, 1'b0, "ack held");
    endtask : wb

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] dummy;
        wb(1'b1, adr, dat, dummy);
    endtask : wr

    // Reads a low word and its high partner as one 64-channel view.
    task automatic rd64(input logic [7:0] adr, output logic [63:0] val);
        logic [31:0] lo;
        logic [31:0] hi;
        wb(1'b0, adr, 32'h0000_0000, lo);
        wb(1'b0, adr + 8'h04, 32'h0000_0000, hi);
        val = {hi, lo};
    endtask : rd64

    task automatic end_of_test();
        if (bad_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset_map();
        logic [31:0] r;
        for (int a = 0; a <= 'h3C; a += 4)
        begin
            wb(1'b0, 8'(a), 32'h0000_0000, r);
            chk(r, 32'h0000_0000, "reset or write-only word");
        end
    endtask : t_reset_map

    // Three trigger kinds at once, then a held level on a busy channel must be dropped.
    task automatic t_trigger_block();
        @(posedge clock);
        manual_trigger_set[5] <= 1'b1;
        external_event_latch[40] <= 1'b1;
        chained_event_latch[63] <= 1'b1;
        @(posedge clock);
        manual_trigger_set[5] <= 1'b0;
        chained_event_latch[63] <= 1'b0;
        #1 chk(transfer_request, 64'h8000_0100_0000_0020, "request");
        @(posedge clock);
        #1 chk(transfer_request, 64'h0, "blocked request");
        @(posedge clock);
        external_event_latch[40] <= 1'b0;
        wr(OFS_QS_LO, 32'hFFFF_FFFF);
        rd64(OFS_QS_LO, v);
        chk(v, 64'h8000_0100_0000_0020, "status");
        wr(OFS_QS_CLR_HI, 32'h0000_0100);
        rd64(OFS_QS_LO, v);
        chk(v, 64'h8000_0000_0000_0020, "partial clear");
        @(posedge clock);
        external_event_latch[40] <= 1'b1;
        @(posedge clock);
        external_event_latch[40] <= 1'b0;
        #1 chk(transfer_request, 64'h0000_0100_0000_0000, "request after clear");
        wr(OFS_QS_CLR_LO, 32'h0000_0020);
        wr(OFS_QS_CLR_HI, 32'h8000_0100);
        rd64(OFS_QS_LO, v);
        chk(v, 64'h0, "all cleared");
    endtask : t_trigger_block

    // Hardware clear from the queue, and a set meeting a clear in one cycle.
    task automatic t_dequeue();
        @(posedge clock);
        manual_trigger_set[7] <= 1'b1;
        @(posedge clock);
        manual_trigger_set[7] <= 1'b0;
        deq <= '{valid: 1'b1, chan: 6'd7, hw_clear: 1'b1};
        @(posedge clock);
        manual_trigger_set[9] <= 1'b1;
        deq <= '{valid: 1'b1, chan: 6'd9, hw_clear: 1'b1};
        @(posedge clock);
        manual_trigger_set[9] <= 1'b0;
        deq <= '{valid: 1'b1, chan: 6'd9, hw_clear: 1'b0};
        @(posedge clock);
        deq <= '0;
        rd64(OFS_QS_LO, v);
        chk(v, 64'h0000_0000_0000_0200, "queue clear and set priority");
        wr(OFS_QS_CLR_LO, 32'h0000_0200);
    endtask : t_dequeue

    task automatic t_enable();
        wr(OFS_EN_LO, 32'hFFFF_FFFF);
        rd64(OFS_EN_LO, v);
        chk(v, 64'h0, "direct enable write");
        wr(OFS_ENSET_LO, 32'h0000_0009);
        wr(OFS_ENSET_HI, 32'h8000_0000);
        rd64(OFS_EN_LO, v);
        chk(v, 64'h8000_0000_0000_0009, "enable set");
        wr(OFS_DIS_LO, 32'h0000_0001);
        rd64(OFS_EN_LO, v);
        chk(v, 64'h8000_0000_0000_0008, "enable clear");
    endtask : t_enable

    task automatic send_code(input logic [5:0] c, input logic exp_irq);
        @(posedge clock);
        cmp <= '{valid: 1'b1, code: c};
        @(posedge clock);
        cmp <= '0;
        repeat (2) @(posedge clock);
        #1 chk(irq, exp_irq, "interrupt level");
    endtask : send_code

    task automatic t_irq();
        send_code(6'd0, 1'b0);
        send_code(6'd3, 1'b1);
        send_code(6'd63, 1'b1);
        rd64(OFS_PEND_LO, v);
        chk(v, 64'h8000_0000_0000_0009, "pending");
        wr(OFS_PEND_CLR_LO, 32'h0000_0009);
        wr(OFS_PEND_CLR_HI, 32'h8000_0000);
        repeat (2) @(posedge clock);
        #1 chk(irq, 1'b0, "interrupt after clear");
        wr(OFS_DIS_HI, 32'h8000_0000);
        send_code(6'd63, 1'b0);
        rd64(OFS_EN_LO, v);
        chk(v, 64'h0000_0000_0000_0008, "enable high clear");
    endtask : t_irq

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset held for twelve cycles, then the scenarios.
    initial
    begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        t_reset_map();
        t_trigger_block();
        t_dequeue();
        t_enable();
        t_irq();
        end_of_test();
    end

    // Watchdog sized well above the few hundred cycles the scenarios need.
    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count++;
        end_of_test();
    end

endmodule : dqsie_top_tb
